// ### rtl/acq_memory_dma_control.sv
// Purpose: single-shot ring recorder plus command/status DMA control
// Assumes: samples arrive on clk as acq_sample_type; trigger is a pin
// Notes:   a transfer streams samples oldest first, one byte per sample

`timescale 1ns/1ps

module acq_memory_dma_control #(
    parameter int MEM_DEPTH = 4096
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [acq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // sample source and trigger pin
    input wire acq_pkg::acq_sample_type sample_in,
    input wire logic trigger_pin,
    // outgoing transfer stream
    output acq_pkg::acq_stream_type dma_out,
    input wire logic dma_ready
);
    import acq_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);

    // refused at elaboration: the ring wrap needs a power-of-two depth
    if (MEM_DEPTH < 8 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad
        $error("MEM_DEPTH must be a power of two, at least 8");
    end

    // ========================================================
    // trigger synchroniser
    logic trig_meta_q;
    logic trig_sync_q;

    // second stage is the only reader of the first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
        end else begin
            trig_meta_q <= trigger_pin;
            trig_sync_q <= trig_meta_q;
        end
    end

    // ========================================================
    // register file and bus decode
    logic [31:0] mode_q;
    logic [63:0] memsize_q;
    logic [63:0] post_q;
    logic [31:0] notify_q;
    logic [31:0] xfer_len_q;
    logic [31:0] timeout_q;
    logic [3:0] status_q;
    logic busy_q;
    logic wait_q;
    logic [31:0] tmo_cnt_q;
    logic [31:0] rdata_d;
    logic [31:0] be_mask;
    logic [15:0] idx;
    logic req;
    logic first_d;
    logic wr_first;
    logic [31:0] cmd;
    logic wait_ok;
    acq_rec_state_type rec_q;
    acq_dma_state_type dma_q;

    assign idx = avs_address[17:2];
    assign req = avs_read | avs_write;
    assign first_d = req & avs_waitrequest & !busy_q;
    assign wr_first = first_d & avs_write;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // commands act on the first cycle a write is seen
    assign cmd = (wr_first && idx == IDX_CMD) ? (avs_writedata & be_mask)
                                               : 32'h0000_0000;

    // wait is over on a block, an end, a fault, a timeout, or nothing left to wait on
    assign wait_ok = status_q[0] | status_q[1] | status_q[3] |
                     (dma_q == DMA_IDLE) |
                     (timeout_q != 32'h0000_0000 && tmo_cnt_q >= timeout_q);

    // read multiplexer; unmapped words read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (idx)
            IDX_STATUS: rdata_d = {20'h00000, status_q, 8'h00};
            IDX_MODE: rdata_d = mode_q;
            IDX_MEMSIZE: rdata_d = memsize_q[31:0];
            IDX_MEMSIZE_HI: rdata_d = memsize_q[63:32];
            IDX_POST: rdata_d = post_q[31:0];
            IDX_POST_HI: rdata_d = post_q[63:32];
            IDX_NOTIFY: rdata_d = notify_q;
            IDX_XFER_LEN: rdata_d = xfer_len_q;
            IDX_TIMEOUT: rdata_d = timeout_q;
            IDX_REC_STATE: rdata_d = {27'h0000000, rec_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // handshake: waitrequest drops one cycle per access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            wait_q <= 1'b0;
            tmo_cnt_q <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
            busy_q <= 1'b0;
            wait_q <= 1'b0;
        end else if (first_d) begin
            busy_q <= 1'b1;
            tmo_cnt_q <= 32'h0000_0000;
            wait_q <= (cmd & CMD_TRANSFER_WAIT) != 32'h0000_0000;
            // read data is loaded a cycle later, so no answer yet
            avs_waitrequest <= 1'b1;
        end else if (busy_q && wait_q) begin
            // bus stays stalled while the wait command blocks
            tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
            if (wait_ok) begin
                avs_waitrequest <= 1'b0;
            end
        end else if (busy_q) begin
            avs_readdata <= rdata_d;
            avs_waitrequest <= 1'b0;
        end
    end

    // plain configuration writes, byte-enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= RST_MODE;
            memsize_q <= RST_MEMSIZE;
            post_q <= RST_POST;
            notify_q <= RST_NOTIFY;
            xfer_len_q <= RST_XFER_LEN;
            timeout_q <= RST_TIMEOUT;
        end else if (wr_first) begin
            case (idx)
                IDX_MODE: mode_q <= (mode_q & ~be_mask) |
                                    (avs_writedata & be_mask);
                IDX_MEMSIZE: memsize_q[31:0] <= (memsize_q[31:0] & ~be_mask)
                                    | (avs_writedata & be_mask);
                IDX_MEMSIZE_HI: memsize_q[63:32] <= (memsize_q[63:32] &
                                    ~be_mask) | (avs_writedata & be_mask);
                IDX_POST: post_q[31:0] <= (post_q[31:0] & ~be_mask) |
                                    (avs_writedata & be_mask);
                IDX_POST_HI: post_q[63:32] <= (post_q[63:32] & ~be_mask) |
                                    (avs_writedata & be_mask);
                IDX_NOTIFY: notify_q <= (notify_q & ~be_mask) |
                                    (avs_writedata & be_mask);
                IDX_XFER_LEN: xfer_len_q <= (xfer_len_q & ~be_mask) |
                                    (avs_writedata & be_mask);
                IDX_TIMEOUT: timeout_q <= (timeout_q & ~be_mask) |
                                    (avs_writedata & be_mask);
                default: ;
            endcase
        end
    end

    // ========================================================
    // recorder
    logic [7:0] mem [MEM_DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] end_ptr_q;
    logic [63:0] cnt_q;
    logic [63:0] pre_len;
    logic cfg_bad;
    logic [AW-1:0] ring_top;
    logic smp;

    // pre-trigger length follows from the two size registers
    assign pre_len = memsize_q - post_q;
    // sizes the memory cannot serve are refused instead of wrapping wrong
    assign cfg_bad = (memsize_q == 64'h0) || (post_q > memsize_q) ||
                     (memsize_q > 64'(MEM_DEPTH));
    assign ring_top = AW'(memsize_q - 64'h1);
    assign smp = sample_in.valid;

    // samples are stored on their own strobe, whatever the bus does
    always_ff @(posedge clk) begin
        if (smp && (rec_q == REC_PRE || rec_q == REC_ARMED ||
                    rec_q == REC_POST)) begin
            mem[wr_ptr_q] <= sample_in.data;
        end
    end

    // record sequence: fill pre area, arm, post count, hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rec_q <= REC_IDLE;
            wr_ptr_q <= '0;
            end_ptr_q <= '0;
            cnt_q <= 64'h0;
        end else if ((cmd & CMD_CARD_STOP) != 32'h0000_0000) begin
            rec_q <= REC_IDLE;
        end else if ((cmd & CMD_CARD_START) != 32'h0000_0000 &&
                     mode_q == MODE_SINGLE_SHOT && !cfg_bad) begin
            wr_ptr_q <= '0;
            cnt_q <= 64'h0;
            // trigger stays disarmed until the pre area is full
            rec_q <= (pre_len == 64'h0) ? REC_ARMED : REC_PRE;
        end else begin
            case (rec_q)
                REC_IDLE: rec_q <= REC_IDLE;
                REC_PRE: begin
                    if (smp) begin
                        wr_ptr_q <= (wr_ptr_q == ring_top) ? '0
                                    : wr_ptr_q + 1'b1;
                        cnt_q <= cnt_q + 64'h1;
                        if (cnt_q + 64'h1 >= pre_len) begin
                            rec_q <= REC_ARMED;
                        end
                    end
                end
                REC_ARMED: begin
                    if (smp) begin
                        wr_ptr_q <= (wr_ptr_q == ring_top) ? '0
                                    : wr_ptr_q + 1'b1;
                    end
                    if (trig_sync_q) begin
                        cnt_q <= 64'h0;
                        rec_q <= (post_q == 64'h0) ? REC_DONE : REC_POST;
                        end_ptr_q <= wr_ptr_q;
                    end
                end
                REC_POST: begin
                    if (smp) begin
                        wr_ptr_q <= (wr_ptr_q == ring_top) ? '0
                                    : wr_ptr_q + 1'b1;
                        cnt_q <= cnt_q + 64'h1;
                        if (cnt_q + 64'h1 >= post_q) begin
                            rec_q <= REC_DONE;
                            end_ptr_q <= (wr_ptr_q == ring_top) ? '0
                                         : wr_ptr_q + 1'b1;
                        end
                    end
                end
                // data is kept until the next start
                REC_DONE: rec_q <= REC_DONE;
                default: rec_q <= REC_IDLE;
            endcase
        end
    end

    // ========================================================
    // transfer engine
    logic [AW-1:0] rd_ptr_q;
    logic [31:0] left_q;
    logic [31:0] blk_q;
    logic take;
    logic last_take;
    logic blk_hit;
    logic abort;
    logic start;
    logic overflow_ev;
    logic fault_ev;

    assign abort = (cmd & CMD_TRANSFER_ABORT) != 32'h0000_0000;
    assign start = (cmd & CMD_TRANSFER_START) != 32'h0000_0000;
    assign take = dma_out.valid & dma_ready;
    assign last_take = take && left_q == 32'h0 && dma_q == DMA_RUN;
    assign blk_hit = take && notify_q != 32'h0 &&
                     blk_q + 32'h1 >= notify_q;
    // samples in FIFO mode have no FIFO behind them and are lost
    assign overflow_ev = smp && mode_q == MODE_FIFO_SINGLE;
    // a start with sizes the memory cannot hold is an internal fault
    assign fault_ev = start && !abort && cfg_bad;

    // start is held off until the recording has ended
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_q <= DMA_IDLE;
            rd_ptr_q <= '0;
            left_q <= 32'h0;
            dma_out <= '0;
        end else if (abort) begin
            dma_q <= DMA_IDLE;
            dma_out <= '0;
        end else begin
            case (dma_q)
                DMA_IDLE: begin
                    if (start && !cfg_bad) begin
                        dma_q <= DMA_PEND;
                    end
                end
                DMA_PEND: begin
                    if (rec_q == REC_DONE) begin
                        rd_ptr_q <= end_ptr_q;
                        left_q <= (64'(xfer_len_q) > memsize_q)
                                  ? memsize_q[31:0] : xfer_len_q;
                        dma_q <= DMA_RUN;
                    end
                end
                DMA_RUN: begin
                    if (!dma_out.valid || dma_ready) begin
                        if (left_q != 32'h0) begin
                            dma_out.valid <= 1'b1;
                            dma_out.data <= mem[rd_ptr_q];
                            rd_ptr_q <= (rd_ptr_q == ring_top) ? '0
                                        : rd_ptr_q + 1'b1;
                            left_q <= left_q - 32'h1;
                        end else begin
                            dma_out.valid <= 1'b0;
                            dma_q <= DMA_IDLE;
                        end
                    end
                end
                default: dma_q <= DMA_IDLE;
            endcase
        end
    end

    // bytes since the last block event
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blk_q <= 32'h0;
        end else if (abort || start) begin
            blk_q <= 32'h0;
        end else if (blk_hit) begin
            blk_q <= 32'h0;
        end else if (take) begin
            blk_q <= blk_q + 32'h1;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= 4'h0;
        end else begin
            status_q[0] <= (status_q[0] && !abort && !start) ||
                           blk_hit;
            status_q[1] <= (status_q[1] && !abort && !start) ||
                           (last_take && notify_q == 32'h0);
            status_q[2] <= (status_q[2] && !start) || overflow_ev;
            status_q[3] <= (status_q[3] && !start) || fault_ev;
        end
    end

endmodule // acq_memory_dma_control

// ### rtl/acq_pkg.sv
// Purpose: shared constants and carrier types for the acquisition/DMA block
// Assumes: 32-bit Avalon-MM slave, byte addresses are four times the index
// Notes:   64-bit registers take two words, low word at the base index

package acq_pkg;

    // ========================================================
    // register indices and byte address width
    localparam logic [15:0] IDX_CMD = 16'd100;
    localparam logic [15:0] IDX_STATUS = 16'd110;
    localparam logic [15:0] IDX_MODE = 16'd9500;
    localparam logic [15:0] IDX_MEMSIZE = 16'd10000;
    localparam logic [15:0] IDX_MEMSIZE_HI = 16'd10001;
    localparam logic [15:0] IDX_POST = 16'd10100;
    localparam logic [15:0] IDX_POST_HI = 16'd10101;
    localparam logic [15:0] IDX_NOTIFY = 16'd200;
    localparam logic [15:0] IDX_XFER_LEN = 16'd201;
    localparam logic [15:0] IDX_TIMEOUT = 16'd202;
    localparam logic [15:0] IDX_REC_STATE = 16'd203;
    localparam int ADDR_W = 18;

    // ========================================================
    // command bits
    localparam logic [31:0] CMD_CARD_START = 32'h0000_0004;
    localparam logic [31:0] CMD_CARD_STOP = 32'h0000_0040;
    localparam logic [31:0] CMD_TRANSFER_START = 32'h0001_0000;
    localparam logic [31:0] CMD_TRANSFER_WAIT = 32'h0002_0000;
    localparam logic [31:0] CMD_TRANSFER_ABORT = 32'h0004_0000;

    // ========================================================
    // status bits
    localparam int ST_BLOCK_POS = 8;
    localparam int ST_COMPLETE_POS = 9;
    localparam int ST_OVERFLOW_POS = 10;
    localparam int ST_FAULT_POS = 11;

    // ========================================================
    // operating modes and reset values
    localparam logic [31:0] MODE_SINGLE_SHOT = 32'h0000_0001;
    localparam logic [31:0] MODE_FIFO_SINGLE = 32'h0000_0010;
    localparam logic [31:0] RST_MODE = 32'h0000_0001;
    localparam logic [63:0] RST_MEMSIZE = 64'h0000_0000_0000_0400;
    localparam logic [63:0] RST_POST = 64'h0000_0000_0000_0200;
    localparam logic [31:0] RST_NOTIFY = 32'h0000_0000;
    localparam logic [31:0] RST_XFER_LEN = 32'h0000_0400;
    localparam logic [31:0] RST_TIMEOUT = 32'h0000_0000;

    // ========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } acq_sample_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } acq_stream_type;

    typedef enum logic [4:0] {
        REC_IDLE = 5'b00001,
        REC_PRE = 5'b00010,
        REC_ARMED = 5'b00100,
        REC_POST = 5'b01000,
        REC_DONE = 5'b10000
    } acq_rec_state_type;

    typedef enum logic [2:0] {
        DMA_IDLE = 3'b001,
        DMA_PEND = 3'b010,
        DMA_RUN = 3'b100
    } acq_dma_state_type;

endpackage

// ### verification/acq_memory_dma_control_properties.sv
// Purpose: port-level checks for the acquisition and transfer block
// Assumes: full byte lanes on every register write
// Notes:   bound to every instance of the design below the module
`timescale 1ns/1ps

module acq_chk_props #(
    parameter int MEM_DEPTH = 4096
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register bus
    input wire logic [acq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // outgoing stream
    input wire acq_pkg::acq_stream_type dma_out,
    input wire logic dma_ready
);
    import acq_pkg::*;

    // ========================================================
    // helper logic
    logic rd_done;
    logic wr_done;
    logic abort_w;
    logic [31:0] mode_q;
    assign rd_done = avs_read && !avs_waitrequest;
    assign wr_done = avs_write && !avs_waitrequest;
    assign abort_w = avs_write && avs_address == {IDX_CMD, 2'b00}
        && avs_writedata[18];

    // last completed mode write, so readback can be judged
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= RST_MODE;
        end else if (wr_done && avs_address == {IDX_MODE, 2'b00}) begin
            mode_q <= avs_writedata;
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    wait_pulse_a: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_needs_req_a: assert property (
        !avs_waitrequest |-> (avs_read || avs_write))
        else $error("answer given with no request pending");
    read_latency_a: assert property (
        rd_done |-> $past(avs_read, 2))
        else $error("read answered too early");
    status_bits_a: assert property (
        rd_done && avs_address == {IDX_STATUS, 2'b00}
        |-> avs_readdata[31:12] == 20'h0 && avs_readdata[7:0] == 8'h00)
        else $error("status shows bits outside the flag field");
    cmd_readzero_a: assert property (
        rd_done && avs_address == {IDX_CMD, 2'b00} |-> avs_readdata == 32'h0)
        else $error("command register readable");
    mode_readback_a: assert property (
        rd_done && avs_address == {IDX_MODE, 2'b00} |-> avs_readdata == mode_q)
        else $error("mode readback differs from last write");
    stream_hold_a: assert property (
        dma_out.valid && !dma_ready && !abort_w
        |=> dma_out.valid && $stable(dma_out.data))
        else $error("stream byte dropped before it was taken");
    abort_stops_a: assert property (
        wr_done && abort_w |-> !dma_out.valid ##1 !dma_out.valid)
        else $error("stream still running after abort");

    // main scenarios reached
    cover property (rd_done && avs_address == {IDX_STATUS, 2'b00});
    cover property (dma_out.valid && dma_ready);
    cover property (wr_done && abort_w);
endmodule // acq_chk_props

bind acq_memory_dma_control acq_chk_props #(.MEM_DEPTH(MEM_DEPTH)) chk (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dma_out(dma_out),
    .dma_ready(dma_ready));

// ### verification/acq_sink_model.sv
// Purpose: host-side sink that takes the outgoing transfer stream
// Assumes: one byte taken per valid and ready edge
// Notes:   slow pacing stalls every other cycle
`timescale 1ns/1ps

module acq_sink_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // stream from the block
    input wire acq_pkg::acq_stream_type dma_out,
    output logic dma_ready,
    // pacing and capture
    input wire logic slow,
    output int count
);
    import acq_pkg::*;

    logic [7:0] got [0:63];

    // ========================================================
    // pacing: stalls exercise the hold of each byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_ready <= 1'b0;
        end else begin
            dma_ready <= slow ? !dma_ready : 1'b1;
        end
    end

    // capture in arrival order, wraps after 64 bytes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 0;
        end else if (dma_out.valid && dma_ready) begin
            got[count[5:0]] <= dma_out.data;
            count <= count + 1;
        end
    end
endmodule // acq_sink_model

// ### verification/tb.sv
// Purpose: register-level test of recording and transfer control
// Assumes: bus tasks hold each request until waitrequest is seen low
// Notes:   record length kept at 32 samples to keep the run short
`timescale 1ns/1ps

module tb;
    import acq_pkg::*;

    // ========================================================
    // signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    acq_sample_type sample_in = '0;
    logic trigger_pin = 1'b0;
    acq_stream_type dma_out;
    logic dma_ready;
    logic slow = 1'b1;
    logic [7:0] sval = 8'h11;
    logic [7:0] hist [$];
    logic [7:0] exp_q [$];
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int t0;
    int base;

    always #5 clk = ~clk;

    acq_memory_dma_control #(.MEM_DEPTH(64)) dut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_in(sample_in), .trigger_pin(trigger_pin),
        .dma_out(dma_out), .dma_ready(dma_ready));

    acq_sink_model sink (
        .clk(clk), .arst_n(arst_n), .dma_out(dma_out),
        .dma_ready(dma_ready), .slow(slow), .count());

    // ========================================================
    // tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", name, e, g);
            bad_count++;
        end
    endtask

    // waitrequest and read data are taken as sampled at the rising edge
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, idx, d, v);
    endtask

    task automatic rd_chk(input string name, input logic [15:0] idx,
                          input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, idx, 32'h0, v);
        chk(name, e, v);
    endtask

    // one-cycle sample strobes with a gap between them
    task automatic feed(input int n);
        repeat (n) begin
            @(posedge clk);
            sample_in <= {1'b1, sval};
            hist.push_back(sval);
            sval = sval + 8'h01;
            @(posedge clk);
            sample_in <= '0;
        end
    endtask

    task automatic pulse_trigger();
        @(posedge clk);
        trigger_pin <= 1'b1;
        repeat (4) @(posedge clk);
        trigger_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // hang guard, well above the expected few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk("mode", IDX_MODE, RST_MODE);
        rd_chk("memsize", IDX_MEMSIZE, RST_MEMSIZE[31:0]);
        rd_chk("post", IDX_POST, RST_POST[31:0]);
        wr(IDX_STATUS, 32'hFFFF_FFFF);
        rd_chk("status", IDX_STATUS, 32'h0);
        rd_chk("command", IDX_CMD, 32'h0);
        rd_chk("unmapped", 16'h0005, 32'h0);
        wr(IDX_MODE, MODE_FIFO_SINGLE);
        rd_chk("mode", IDX_MODE, MODE_FIFO_SINGLE);
        wr(IDX_MODE, MODE_SINGLE_SHOT);
        // 32 samples, 8 after trigger, so 24 before
        wr(IDX_MEMSIZE, 32'h20);
        wr(IDX_MEMSIZE_HI, 32'h0);
        wr(IDX_POST, 32'h8);
        wr(IDX_POST_HI, 32'h0);
        wr(IDX_XFER_LEN, 32'h20);
        rd_chk("memsize", IDX_MEMSIZE, 32'h20);
        rd_chk("post", IDX_POST, 32'h8);
        wr(IDX_CMD, CMD_CARD_START | CMD_TRANSFER_START);
        rd_chk("state", IDX_REC_STATE, 32'h2);
        pulse_trigger();
        feed(23);
        rd_chk("state", IDX_REC_STATE, 32'h2);
        feed(1);
        rd_chk("state", IDX_REC_STATE, 32'h4);
        feed(5);
        chk("bytes", 32'h0, 32'(sink.count));
        pulse_trigger();
        rd_chk("state", IDX_REC_STATE, 32'h8);
        feed(8);
        rd_chk("state", IDX_REC_STATE, 32'h10);
        exp_q = hist[$-31:$];
        feed(3);
        wr(IDX_CMD, CMD_TRANSFER_WAIT);
        rd_chk("status", IDX_STATUS, 32'h200);
        for (int i = 0; i < 32; i++) begin
            chk("byte", 32'(exp_q[i]), 32'(sink.got[i]));
        end
        // second pass, prompt sink, 16-byte notify
        slow <= 1'b0;
        wr(IDX_NOTIFY, 32'h10);
        wr(IDX_CMD, CMD_TRANSFER_START);
        wr(IDX_CMD, CMD_TRANSFER_WAIT);
        rd_chk("status", IDX_STATUS, 32'h100);
        wr(IDX_CMD, CMD_TRANSFER_ABORT);
        rd_chk("status", IDX_STATUS, 32'h0);
        base = sink.count;
        repeat (20) @(posedge clk);
        chk("bytes", 32'(base), 32'(sink.count));
        // pending transfer with no trigger: wait ends by timeout
        wr(IDX_NOTIFY, 32'h0);
        wr(IDX_TIMEOUT, 32'd40);
        wr(IDX_CMD, CMD_CARD_START | CMD_TRANSFER_START);
        t0 = cycles;
        wr(IDX_CMD, CMD_TRANSFER_WAIT);
        chk("wait", 32'h1,
            32'(cycles - t0 >= 40 && cycles - t0 <= 60));
        wr(IDX_CMD, CMD_TRANSFER_ABORT | CMD_CARD_STOP);
        rd_chk("state", IDX_REC_STATE, 32'h1);
        // refused start, then sample loss in streaming mode
        wr(IDX_MEMSIZE, 32'h0);
        wr(IDX_CMD, CMD_TRANSFER_START);
        rd_chk("status", IDX_STATUS, 32'h800);
        wr(IDX_MODE, MODE_FIFO_SINGLE);
        feed(1);
        rd_chk("status", IDX_STATUS, 32'hC00);
        wr(IDX_MODE, MODE_SINGLE_SHOT);
        wrap_up();
    end
endmodule // tb
